// ==== include/rsrc_pkg.sv ====
// Package: register map, cause layout and timing constants of the reset controller
package rsrc_pkg;
  // APB byte addresses
  localparam logic [11:0] RSRC_ADDR_CAUSE = 12'h0ff0;
  localparam logic [11:0] RSRC_ADDR_WAKE_EN = 12'h0ff4;
  localparam logic [11:0] RSRC_ADDR_WATCHDOG_CONTROL_REG = 12'h0ff8;
  localparam logic [11:0] RSRC_ADDR_DBG_CTL = 12'h0ffc;
  localparam logic [11:0] RSRC_ADDR_OSCILLATOR_CONTROL = 12'h0fec;
  // Cause field positions inside the 8-bit status bytes
  localparam int RSRC_BIT_POR = 7;
  localparam int RSRC_BIT_STOP = 6;
  localparam int RSRC_BIT_WDT = 5;
  localparam int RSRC_BIT_EXT = 4;
  localparam int RSRC_BIT_DBG_RST = 0;
  // Reset values
  localparam logic [7:0] RSRC_WAKE_EN_RST = 8'h00;
  localparam logic [1:0] RSRC_OSC_SEL_IPO = 2'h0;
  localparam logic [15:0] RSRC_VECTOR_ADDR = 16'h0002;
  // Timing: system clock 125 MHz
  localparam int RSRC_CLK_MHZ = 125;
  localparam int RSRC_IPO_START_NS = 4000;
  localparam int RSRC_IPO_START_CYC = (RSRC_IPO_START_NS * RSRC_CLK_MHZ + 999) / 1000;
  localparam int RSRC_HOLD_IPO = 66;
  localparam int RSRC_HOLD_XTAL_IPO = 5000;
  localparam int RSRC_PIN_MIN_CYC = 3;
  localparam int RSRC_STOP_FILT_CYC = 8;
  localparam int RSRC_IPO_DIV = 23;
  // Sticky cause record
  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic external_reset_flag;
  } rsrc_cause_s;
  typedef enum logic [2:0] {ST_RUN, ST_SUPPLY, ST_OSC, ST_HOLD, ST_PIN} rsrc_state_e;
endpackage

// ==== hw/rsrc_pin_filter.sv ====
// Synchroniser and minimum-width filter for an active-low pin
`timescale 1ns/1ps
`default_nettype none
module rsrc_pin_filter #(
  parameter int STAGES = 2,
  parameter int CW = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin_n,
  input wire logic [CW-1:0] min_len,
  output logic active
);
  logic [STAGES-1:0] sync_reg;
  logic [CW-1:0] low_cnt_reg;

  // First stage feeds only the second; pin idles high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= '1;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], pin_n}; // RULE22
    end
  end

  // Count consecutive low samples; short pulses never qualify
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= '0;
      active <= 1'b0;
    end else if (sync_reg[STAGES-1]) begin
      low_cnt_reg <= '0;
      active <= 1'b0;
    end else begin
      if (low_cnt_reg != '1) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
      end
      // One spare bit so a saturated count still compares as long
      active <= ((CW+1)'(low_cnt_reg) + 1'b1 >= (CW+1)'(min_len)); // RULE13 RULE14
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_pulse_min_len: assert property ($rose(active) |-> $past(low_cnt_reg) + 1'b1 >= $past(min_len)) // RULE13
    else $error("pin qualified before minimum width");
endmodule
`default_nettype wire

// ==== hw/rsrc_ctrl.sv ====
// Reset and stop-mode recovery controller with APB register slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - POR, brownout, watchdog, pin, debugger start reset
// RULE2 - In stop, watchdog or GPIO edge recovers
// RULE3 - 4 us oscillator start, then 66 ticks
// RULE4 - Crystal option stretches hold to 5000 ticks
// RULE5 - Supply resets count only after supply good
// RULE6 - Pin still low extends reset until release
// RULE7 - Reset forces GPIO inputs, pull-ups off
// RULE8 - CPU, peripherals idle; oscillators keep running
// RULE9 - Reset loads defined reset values
// RULE10 - CPU fetches vector at 0002h/0003h
// RULE11 - System reset selects internal oscillator
// RULE12 - Recovery keeps registers except watchdog, oscillator
// RULE13 - Run mode ignores pin pulses under three clocks
// RULE14 - Stop mode: supply, debug pin, long pin reset
// RULE15 - Debugger reset spares debugger logic
// RULE16 - Power-on counter expires before release
// RULE17 - Power-on completion sets power-on flag
// RULE18 - Pin reset sets external flag
// RULE19 - Watchdog cause sets watchdog flag
// RULE20 - Recovery sets stop flag
// RULE21 - Watchdog option 1 resets, 0 interrupts
// RULE22 - Pin passes a multi-stage synchroniser
module rsrc_ctrl
  import rsrc_pkg::*;
#(
  parameter int GPIO_W = 8,
  parameter int IPO_DIV = RSRC_IPO_DIV,
  parameter int HOLD_XTAL_IPO = RSRC_HOLD_XTAL_IPO
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_above_por,
  input wire logic brownout_detect,
  input wire logic wdt_timeout,
  input wire logic watchdog_reset_select_option,
  input wire logic xtal_option_en,
  input wire logic reset_pin_n,
  input wire logic reset_pin_func_en,
  input wire logic debug_pin_n,
  input wire logic stop_mode,
  input wire logic [GPIO_W-1:0] gpio_in,
  output logic cpu_reset,
  output logic periph_reset,
  output logic debugger_reset,
  output logic gpio_force_input,
  output logic gpio_pullup_disable,
  output logic xtal_osc_run,
  output logic wdt_osc_run,
  output logic wdt_irq_req,
  output logic [1:0] sysclk_sel,
  output logic vector_fetch,
  output logic [15:0] vector_addr
);
  localparam int HW = 13;
  localparam logic [HW-1:0] HOLD_SHORT = HW'(RSRC_HOLD_IPO);
  localparam logic [HW-1:0] HOLD_LONG = HW'(HOLD_XTAL_IPO);
  localparam logic [9:0] OSC_CYC = 10'(RSRC_IPO_START_CYC);
  localparam logic [7:0] DIV_MAX = 8'(IPO_DIV - 1);

  rsrc_state_e state_reg;
  rsrc_cause_s cause_reg, pend_reg;
  logic smr_reg;
  logic [9:0] osc_cnt_reg;
  logic [HW-1:0] hold_cnt_reg;
  logic [7:0] div_reg;
  logic ipo_tick;
  logic [GPIO_W-1:0] wake_en_reg, gpio_prev_reg, gpio_edge;
  logic dbg_rst_reg, dbg_src_reg;
  logic [1:0] osc_sel_reg;
  logic pin_act, dbg_act, supply_bad, pin_req, wdt_rst_req, sys_req, smr_req, wake_any;
  logic [3:0] pin_len;
  logic hold_done, release_now, apb_wr, wdt_clr_wr;

  ////////////////////////////////////////////////////////////////////////
  // Pin qualification: stop mode uses the longer analog-like delay
  assign pin_len = stop_mode ? 4'(RSRC_STOP_FILT_CYC) : 4'(RSRC_PIN_MIN_CYC); // RULE13 RULE14

  rsrc_pin_filter #(.STAGES(2), .CW(4)) u_pin_filt (
    .clk(clk),
    .arst_n(arst_n),
    .pin_n(reset_pin_n),
    .min_len(pin_len),
    .active(pin_act)
  );

  rsrc_pin_filter #(.STAGES(2), .CW(4)) u_dbg_filt (
    .clk(clk),
    .arst_n(arst_n),
    .pin_n(debug_pin_n),
    .min_len(4'd1),
    .active(dbg_act)
  );

  ////////////////////////////////////////////////////////////////////////
  // Internal oscillator tick: one-cycle enable from the divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
    end else if (div_reg == DIV_MAX) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign ipo_tick = (div_reg == DIV_MAX);

  // GPIO wake edges, one detector per pin
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_W; gi++) begin : g_wake
      assign gpio_edge[gi] = wake_en_reg[gi] & (gpio_in[gi] ^ gpio_prev_reg[gi]);
    end
  endgenerate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_prev_reg <= '0;
    end else begin
      gpio_prev_reg <= gpio_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request decode; system reset outranks recovery
  assign supply_bad = !supply_above_por || brownout_detect; // RULE1
  assign pin_req = reset_pin_func_en && pin_act;
  assign wdt_rst_req = wdt_timeout && watchdog_reset_select_option && !stop_mode; // RULE21
  assign wake_any = |gpio_edge;
  assign sys_req = pin_req || wdt_rst_req || dbg_rst_reg || (stop_mode && dbg_act); // RULE1 RULE14
  assign smr_req = stop_mode && (wdt_timeout || wake_any); // RULE2
  assign hold_done = ipo_tick && (hold_cnt_reg >= (xtal_option_en ? HOLD_LONG : HOLD_SHORT) - 1'b1); // RULE4
  assign release_now = (state_reg == ST_HOLD && hold_done && !pin_req) || (state_reg == ST_PIN && !pin_req);

  // Sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_SUPPLY;
      smr_reg <= 1'b0;
    end else if (supply_bad) begin
      state_reg <= ST_SUPPLY; // RULE5
      smr_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (sys_req) begin
            state_reg <= ST_OSC; // RULE1
            smr_reg <= 1'b0;
          end else if (smr_req) begin
            state_reg <= ST_OSC; // RULE2
            smr_reg <= 1'b1;
          end
        end
        ST_SUPPLY: begin
          state_reg <= ST_OSC; // RULE5 RULE16
        end
        ST_OSC: begin
          if (osc_cnt_reg == OSC_CYC - 1'b1) begin
            state_reg <= ST_HOLD; // RULE3
          end
        end
        ST_HOLD: begin
          if (hold_done) begin
            state_reg <= pin_req ? ST_PIN : ST_RUN; // RULE6
          end
        end
        ST_PIN: begin
          if (!pin_req) begin
            state_reg <= ST_RUN; // RULE6
          end
        end
        default: state_reg <= ST_SUPPLY;
      endcase
    end
  end

  // Start-up and hold counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_reg <= '0;
      hold_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= (state_reg == ST_OSC) ? osc_cnt_reg + 1'b1 : '0; // RULE3
      if (state_reg != ST_HOLD) begin
        hold_cnt_reg <= '0;
      end else if (ipo_tick) begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1; // RULE3 RULE4 RULE16
      end
    end
  end

  // Pending cause latched as the sequence starts, held until release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_reset_flag: 1'b0};
      dbg_src_reg <= 1'b0;
    end else if (supply_bad) begin
      pend_reg <= '{por: 1'b1, stop: 1'b0, wdt: 1'b0, external_reset_flag: 1'b0};
      dbg_src_reg <= 1'b0;
    end else if (state_reg == ST_RUN && (sys_req || smr_req)) begin
      // Request bit clears itself, so its source is remembered here
      dbg_src_reg <= dbg_rst_reg && !pin_req && !wdt_rst_req; // RULE15
      pend_reg.por <= sys_req && !pin_req && !wdt_rst_req; // RULE15
      pend_reg.external_reset_flag <= sys_req && pin_req; // RULE18
      pend_reg.wdt <= wdt_timeout; // RULE19
      pend_reg.stop <= !sys_req; // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: replaced by the pending cause at system reset completion;
  // a set in the same cycle as a software clear wins
  assign apb_wr = psel && penable && pready && pwrite;
  assign wdt_clr_wr = apb_wr && paddr == RSRC_ADDR_WATCHDOG_CONTROL_REG;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_reg <= '0;
    end else if (release_now) begin
      if (!smr_reg) begin
        cause_reg <= pend_reg; // RULE17 RULE18 RULE19
      end else begin
        cause_reg.stop <= 1'b1; // RULE12 RULE20
        cause_reg.wdt <= pend_reg.wdt; // RULE19
      end
    end else if (wdt_clr_wr) begin
      cause_reg <= cause_reg & ~rsrc_cause_s'(pwdata[RSRC_BIT_POR:RSRC_BIT_EXT]);
    end
  end

  // Control registers with defined reset values reload on system reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_en_reg <= GPIO_W'(RSRC_WAKE_EN_RST);
      osc_sel_reg <= RSRC_OSC_SEL_IPO;
    end else if (state_reg != ST_RUN) begin
      if (!smr_reg) begin
        wake_en_reg <= GPIO_W'(RSRC_WAKE_EN_RST); // RULE9
      end
      osc_sel_reg <= RSRC_OSC_SEL_IPO; // RULE11 RULE12
    end else if (apb_wr && paddr == RSRC_ADDR_WAKE_EN) begin
      wake_en_reg <= pwdata[GPIO_W-1:0];
    end else if (apb_wr && paddr == RSRC_ADDR_OSCILLATOR_CONTROL) begin
      osc_sel_reg <= pwdata[1:0];
    end
  end

  // Debugger request bit clears itself once its reset sequence starts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dbg_rst_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      dbg_rst_reg <= 1'b0; // RULE15
    end else if (apb_wr && paddr == RSRC_ADDR_DBG_CTL) begin
      dbg_rst_reg <= pwdata[RSRC_BIT_DBG_RST]; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, registered answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        if (paddr == RSRC_ADDR_CAUSE || paddr == RSRC_ADDR_WATCHDOG_CONTROL_REG) begin
          prdata <= {24'h0000_00, cause_reg, 4'h0};
        end else if (paddr == RSRC_ADDR_WAKE_EN) begin
          prdata <= 32'(wake_en_reg);
        end else if (paddr == RSRC_ADDR_DBG_CTL) begin
          prdata <= {31'h0000_0000, dbg_rst_reg};
        end else if (paddr == RSRC_ADDR_OSCILLATOR_CONTROL) begin
          prdata <= {30'h0000_0000, osc_sel_reg};
        end else begin
          pslverr <= 1'b1; // Unmapped address
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset outputs, all registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_reset <= 1'b1;
      periph_reset <= 1'b1;
      debugger_reset <= 1'b1;
      gpio_force_input <= 1'b1;
      gpio_pullup_disable <= 1'b1;
      vector_fetch <= 1'b0;
    end else begin
      cpu_reset <= (state_reg != ST_RUN) && !release_now; // RULE8
      periph_reset <= (state_reg != ST_RUN) && !smr_reg && !release_now; // RULE8 RULE9 RULE12
      debugger_reset <= (state_reg != ST_RUN) && pend_reg.por && !dbg_src_reg && !release_now; // RULE15
      gpio_force_input <= (state_reg != ST_RUN) && !smr_reg && !release_now; // RULE7
      gpio_pullup_disable <= (state_reg != ST_RUN) && !smr_reg && !release_now; // RULE7
      vector_fetch <= release_now; // RULE10
    end
  end

  // Oscillator-run, vector, clock-select and watchdog interrupt outputs also come from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xtal_osc_run <= 1'b1;
      wdt_osc_run <= 1'b1;
      vector_addr <= RSRC_VECTOR_ADDR;
      sysclk_sel <= RSRC_OSC_SEL_IPO;
      wdt_irq_req <= 1'b0;
    end else begin
      xtal_osc_run <= 1'b1; // RULE8
      wdt_osc_run <= 1'b1; // RULE8
      vector_addr <= RSRC_VECTOR_ADDR; // RULE10
      sysclk_sel <= osc_sel_reg; // RULE11
      wdt_irq_req <= wdt_timeout && !watchdog_reset_select_option; // RULE21
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_sys_req_start: assert property (state_reg == ST_RUN && sys_req && !supply_bad |=> state_reg == ST_OSC && !smr_reg) // RULE1
    else $error("system reset not started");
  chk_smr_start: assert property (state_reg == ST_RUN && !sys_req && smr_req && !supply_bad |=> smr_reg) // RULE2
    else $error("stop recovery not started");
  chk_osc_start_len: assert property ($rose(state_reg == ST_HOLD) |-> $past(osc_cnt_reg) == OSC_CYC - 1'b1) // RULE3
    else $error("oscillator start time wrong");
  chk_hold_release: assert property ($fell(state_reg == ST_HOLD) && !$past(supply_bad)
    |-> $past(hold_cnt_reg) == (($past(xtal_option_en)) ? HOLD_LONG : HOLD_SHORT) - 1'b1) // RULE3 RULE4
    else $error("hold count wrong");
  chk_supply_wait: assert property (supply_bad |=> state_reg == ST_SUPPLY ##1 cpu_reset) // RULE5
    else $error("counting before supply good");
  chk_pin_wait: assert property (state_reg == ST_PIN && pin_req |=> cpu_reset) // RULE6
    else $error("released while pin asserted");
  chk_gpio_force: assert property (state_reg != ST_RUN && !smr_reg && !release_now |=> gpio_force_input && gpio_pullup_disable) // RULE7
    else $error("gpio not forced during reset");
  chk_por_flag: assert property (release_now && !smr_reg && pend_reg.por |=> cause_reg.por) // RULE17
    else $error("power-on flag not set");
  chk_stop_flag: assert property (release_now && smr_reg |=> cause_reg.stop && !periph_reset) // RULE20 RULE12
    else $error("stop flag not set");
  chk_dbg_spared: assert property (state_reg != ST_RUN && dbg_src_reg |=> !debugger_reset) // RULE15
    else $error("debugger reset by its own request");

  cov_por: cover property (state_reg == ST_SUPPLY ##1 state_reg == ST_OSC);
  cov_smr: cover property (release_now && smr_reg);
  cov_pin_wait: cover property (state_reg == ST_PIN ##1 state_reg == ST_RUN);
  cov_dbg: cover property (state_reg == ST_RUN && dbg_rst_reg);
endmodule
`default_nettype wire

// ==== verification/rsrc_far_side.sv ====
// Far-side model: supply monitor, reset pin, debug pin, watchdog and wake pins
`timescale 1ns/1ps
`default_nettype none
module rsrc_far_side (
  input wire logic clk,
  output logic supply_above_por,
  output logic brownout_detect,
  output logic wdt_timeout,
  output logic watchdog_reset_select_option,
  output logic xtal_option_en,
  output logic reset_pin_n,
  output logic reset_pin_func_en,
  output logic debug_pin_n,
  output logic stop_mode,
  output logic [7:0] gpio_in
);
  // Power-up state: supply still below threshold, reset and debug pins idle at their pull-up level
  initial begin
    supply_above_por = 1'b0;
    brownout_detect = 1'b0;
    wdt_timeout = 1'b0;
    watchdog_reset_select_option = 1'b1;
    xtal_option_en = 1'b0;
    reset_pin_n = 1'b1;
    reset_pin_func_en = 1'b1;
    debug_pin_n = 1'b1;
    stop_mode = 1'b0;
    gpio_in = 8'h5a;
  end
  // Every source changes just after a clock edge, never mid-cycle
  task automatic set_supply(input logic v);
    @(posedge clk);
    supply_above_por <= v;
  endtask
  task automatic set_pins(input logic rst_n, input logic dbg_n);
    @(posedge clk);
    reset_pin_n <= rst_n;
    debug_pin_n <= dbg_n;
  endtask
  task automatic set_aux(input logic bo, input logic fen);
    @(posedge clk);
    brownout_detect <= bo;
    reset_pin_func_en <= fen;
  endtask
  task automatic set_mode(input logic stop, input logic wopt, input logic xtal);
    @(posedge clk);
    stop_mode <= stop;
    watchdog_reset_select_option <= wopt;
    xtal_option_en <= xtal;
  endtask
  // Time-out is a level held for n cycles
  task automatic wdt_pulse(input int n);
    @(posedge clk);
    wdt_timeout <= 1'b1;
    repeat (n) @(posedge clk);
    wdt_timeout <= 1'b0;
  endtask
  task automatic gpio_flip(input int i);
    @(posedge clk);
    gpio_in[i] <= ~gpio_in[i];
  endtask
endmodule
`default_nettype wire

// ==== verification/reset_stop_recovery_ctrl_tb_top.sv ====
// Testbench: register and sequencer tests of the reset controller
`timescale 1ns/1ps
`default_nettype none
module reset_stop_recovery_ctrl_tb_top import rsrc_pkg::*;;
  localparam int DIV = 2;
  localparam int XH = 100;
  localparam int T66 = RSRC_IPO_START_CYC + RSRC_HOLD_IPO * DIV;
  localparam int TXH = RSRC_IPO_START_CYC + XH * DIV;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, cpu_reset, periph_reset, debugger_reset;
  logic supply_above_por, brownout_detect, wdt_timeout, wopt, xtal_option_en, reset_pin_n, reset_pin_func_en;
  logic debug_pin_n, stop_mode, gpio_force_input, gpio_pullup_disable, xtal_osc_run, wdt_osc_run;
  logic wdt_irq_req, vector_fetch;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] gpio_in;
  logic [1:0] sysclk_sel;
  logic [15:0] vector_addr;
  logic er;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  rsrc_ctrl #(.GPIO_W(8), .IPO_DIV(DIV), .HOLD_XTAL_IPO(XH)) u_rsrc_ctrl (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_above_por(supply_above_por), .brownout_detect(brownout_detect),
    .wdt_timeout(wdt_timeout), .watchdog_reset_select_option(wopt), .xtal_option_en(xtal_option_en),
    .reset_pin_n(reset_pin_n), .reset_pin_func_en(reset_pin_func_en), .debug_pin_n(debug_pin_n),
    .stop_mode(stop_mode), .gpio_in(gpio_in), .cpu_reset(cpu_reset), .periph_reset(periph_reset),
    .debugger_reset(debugger_reset), .gpio_force_input(gpio_force_input), .gpio_pullup_disable(gpio_pullup_disable),
    .xtal_osc_run(xtal_osc_run), .wdt_osc_run(wdt_osc_run), .wdt_irq_req(wdt_irq_req), .sysclk_sel(sysclk_sel),
    .vector_fetch(vector_fetch), .vector_addr(vector_addr));
  rsrc_far_side u_rsrc_far_side (.clk(clk), .supply_above_por(supply_above_por), .brownout_detect(brownout_detect),
    .wdt_timeout(wdt_timeout), .watchdog_reset_select_option(wopt), .xtal_option_en(xtal_option_en),
    .reset_pin_n(reset_pin_n), .reset_pin_func_en(reset_pin_func_en), .debug_pin_n(debug_pin_n),
    .stop_mode(stop_mode), .gpio_in(gpio_in));
  ////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard: whole run is a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd & m);
    chk("pslverr", 1'b0, er);
  endtask
  // Waits for the CPU release and checks the hold length and the release outputs
  task automatic wait_rel(input string nm, input int lo, input int hi);
    int n;
    n = 0;
    while (cpu_reset !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    while (cpu_reset === 1'b1 && n < 20000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(nm, 1'b1, n >= lo && n <= hi);
    chk("vector_fetch", 1'b1, vector_fetch);
    chk("vector_addr", 16'h0002, vector_addr);
    chk("sysclk_sel", RSRC_OSC_SEL_IPO, sysclk_sel);
    @(posedge clk);
    #1 chk("vector_fetch end", 1'b0, vector_fetch);
    repeat (2) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge clk);
    chk("gpio_force_input", 1'b1, gpio_force_input);
    chk("gpio_pullup_disable", 1'b1, gpio_pullup_disable);
    arst_n <= 1'b1;
    // Power-on: nothing released before the supply is good
    repeat (300) @(posedge clk);
    #1 chk("held low supply", 1'b1, cpu_reset);
    chk("periph held", 1'b1, periph_reset);
    chk("xtal_osc_run", 1'b1, xtal_osc_run & wdt_osc_run);
    u_rsrc_far_side.set_supply(1'b1);
    wait_rel("por hold", T66 - 4, T66 + 20);
    rchk("por cause", RSRC_ADDR_CAUSE, 32'h0000_0080, 32'hffff_ffff);
    rchk("wake reset", RSRC_ADDR_WAKE_EN, {24'h0, RSRC_WAKE_EN_RST}, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("unmapped err", 1'b1, er);
    $display("test power_on done");
    // Short pin pulse ignored, long pin low extends reset
    u_rsrc_far_side.set_pins(1'b0, 1'b1);
    u_rsrc_far_side.set_pins(1'b1, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk("short pin", 1'b0, cpu_reset);
    u_rsrc_far_side.set_pins(1'b0, 1'b1);
    repeat (T66 + 200) @(posedge clk);
    #1 chk("pin still low", 1'b1, cpu_reset);
    chk("gpio forced", 1'b1, gpio_force_input & gpio_pullup_disable);
    chk("periph pin", 1'b1, periph_reset);
    u_rsrc_far_side.set_pins(1'b1, 1'b1);
    wait_rel("pin release", 1, 12);
    rchk("ext cause", RSRC_ADDR_WATCHDOG_CONTROL_REG, 32'h0000_0010, 32'hffff_ffff);
    $display("test reset_pin done");
    // Debugger reset with crystal option: longer hold, debugger untouched
    u_rsrc_far_side.set_mode(1'b0, 1'b1, 1'b1);
    apb(1'b1, RSRC_ADDR_DBG_CTL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    #1 chk("dbg reset", 1'b1, cpu_reset);
    chk("debugger spared", 1'b0, debugger_reset);
    wait_rel("xtal hold", TXH - 12, TXH + 20);
    rchk("dbg cause", RSRC_ADDR_CAUSE, 32'h0000_0080, 32'hffff_ffff);
    rchk("dbg self clear", RSRC_ADDR_DBG_CTL, 32'h0000_0000, 32'h0000_0001);
    $display("test debugger done");
    // Watchdog: interrupt when option is 0, reset when 1
    u_rsrc_far_side.set_mode(1'b0, 1'b0, 1'b0);
    u_rsrc_far_side.wdt_pulse(3);
    #1 chk("wdt irq", 1'b1, wdt_irq_req);
    repeat (20) @(posedge clk);
    #1 chk("no wdt reset", 1'b0, cpu_reset);
    u_rsrc_far_side.set_mode(1'b0, 1'b1, 1'b0);
    u_rsrc_far_side.wdt_pulse(1);
    wait_rel("wdt hold", T66 - 12, T66 + 20);
    rchk("wdt cause", RSRC_ADDR_WATCHDOG_CONTROL_REG, 32'h0000_0020, 32'hffff_ffff);
    $display("test watchdog done");
    // Stop mode: only an enabled wake pin recovers, wake enables survive, oscillator select clears
    apb(1'b1, RSRC_ADDR_WAKE_EN, 32'h0000_0001);
    apb(1'b1, RSRC_ADDR_OSCILLATOR_CONTROL, 32'h0000_0003);
    u_rsrc_far_side.set_mode(1'b1, 1'b1, 1'b0);
    u_rsrc_far_side.gpio_flip(1);
    repeat (20) @(posedge clk);
    #1 chk("masked wake", 1'b0, cpu_reset);
    u_rsrc_far_side.gpio_flip(0);
    repeat (6) @(posedge clk);
    #1 chk("recovery", 1'b1, cpu_reset);
    chk("periph kept", 1'b0, periph_reset);
    u_rsrc_far_side.set_mode(1'b0, 1'b1, 1'b0);
    wait_rel("recovery hold", T66 - 12, T66 + 20);
    rchk("stop flag", RSRC_ADDR_WATCHDOG_CONTROL_REG, 32'h0000_0040, 32'h0000_0040);
    rchk("wake kept", RSRC_ADDR_WAKE_EN, 32'h0000_0001, 32'hffff_ffff);
    rchk("osc cleared", RSRC_ADDR_OSCILLATOR_CONTROL, 32'h0000_0000, 32'h0000_0003);
    $display("test stop_recovery done");
    // Stop mode: debug pin low gives a full system reset
    u_rsrc_far_side.set_mode(1'b1, 1'b1, 1'b0);
    u_rsrc_far_side.set_pins(1'b1, 1'b0);
    repeat (20) @(posedge clk);
    #1 chk("debug pin reset", 1'b1, cpu_reset & periph_reset);
    u_rsrc_far_side.set_pins(1'b1, 1'b1);
    u_rsrc_far_side.set_mode(1'b0, 1'b1, 1'b0);
    wait_rel("debug pin hold", T66 - 30, T66 + 20);
    $display("test debug_pin done");
    // Software clear, then watchdog recovery from stop
    apb(1'b1, RSRC_ADDR_WATCHDOG_CONTROL_REG, 32'h0000_00f0);
    rchk("flags cleared", RSRC_ADDR_WATCHDOG_CONTROL_REG, 32'h0000_0000, 32'hffff_ffff);
    u_rsrc_far_side.set_mode(1'b1, 1'b1, 1'b0);
    u_rsrc_far_side.wdt_pulse(1);
    u_rsrc_far_side.set_mode(1'b0, 1'b1, 1'b0);
    wait_rel("wdt recovery", T66 - 12, T66 + 20);
    rchk("wdt stop flags", RSRC_ADDR_WATCHDOG_CONTROL_REG, 32'h0000_0060, 32'hffff_ffff);
    $display("test wdt_recovery done");
    // Brownout restarts the supply wait; disabled pin function ignores the pin
    u_rsrc_far_side.set_aux(1'b1, 1'b0);
    repeat (20) @(posedge clk);
    #1 chk("brownout hold", 1'b1, cpu_reset & debugger_reset);
    u_rsrc_far_side.set_aux(1'b0, 1'b0);
    wait_rel("brownout release", T66 - 4, T66 + 20);
    rchk("brownout cause", RSRC_ADDR_CAUSE, 32'h0000_0080, 32'hffff_ffff);
    u_rsrc_far_side.set_pins(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk("pin disabled", 1'b0, cpu_reset);
    u_rsrc_far_side.set_pins(1'b1, 1'b1);
    $display("test brownout done");
    wrap_up();
  end
endmodule
`default_nettype wire
